/* srm_array.sv */
// 512 x 16 static array with a bus port and an emulation read port
`timescale 1ns/1ns
module srm_array (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// array side
	srm_mem_if.array mem
);
	import srm_pkg::*;

	logic [15:0] mem_q [0:SRM_ARRAY_WORDS-1];
	logic [15:0] rdat_q;
	logic [15:0] erdat_q;

	assign mem.rdat = rdat_q;
	assign mem.erdat = erdat_q;

	// contents never reset, kept across stop mode R9
	// no asynchronous reset here, so no mid-access corruption path R7
	always_ff @(posedge clk_i) begin
		if (mem.we && mem.be[1]) begin
			mem_q[mem.addr][15:8] <= mem.wdat[15:8];
		end
		if (mem.we && mem.be[0]) begin
			mem_q[mem.addr][7:0] <= mem.wdat[7:0];
		end
	end

	// registered reads; emulation port has rom-like one clock latency
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= 16'h0000;
			erdat_q <= 16'h0000;
		end else begin
			rdat_q <= mem_q[mem.addr];
			erdat_q <= mem_q[mem.eaddr]; // R12
		end
	end

endmodule : srm_array

/* srm_cpu_model.sv */
// cpu bus master model on the wishbone side
`timescale 1ns/1ns
module srm_cpu_model (
	// clock
	input wire logic clk_i,
	// wishbone master
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [23:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	input wire logic ack_i
);
	initial begin
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
	end
	// one classic cycle, gives up after 12 clocks without ack
	task automatic bus(input logic w, input logic [23:0] a,
		input logic [3:0] s, input logic [31:0] d, output logic ok);
		int n;
		n = 0;
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'h3, w, a, s, d};
		// ack is looked at only on rising edges, request held until then
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 12);
		ok = (ack_i === 1'b1);
		{cyc_o, stb_o} <= 2'h0;
		adr_o <= ~a;
		dat_o <= ~d;
		@(posedge clk_i);
	endtask : bus
endmodule : srm_cpu_model

/* srm_mem_if.sv */
// carrier between the control logic and the ram array
`timescale 1ns/1ns
interface srm_mem_if;
	import srm_pkg::*;

	logic [SRM_WA-1:0] addr;
	logic [15:0] wdat;
	logic [1:0] be;
	logic we;
	logic [15:0] rdat;
	logic [SRM_WA-1:0] eaddr;
	logic [15:0] erdat;

	modport ctrl (
		output addr, wdat, be, we, eaddr,
		input rdat, erdat
	);

	modport array (
		input addr, wdat, be, we, eaddr,
		output rdat, erdat
	);

endinterface : srm_mem_if

/* srm_pkg.sv */
// constants and types for the standby ram mode control block
package srm_pkg;

	// wishbone widths
	localparam int SRM_ADR_W = 24;
	localparam int SRM_DAT_W = 32;

	// register block placement and register indices (byte addr = 4 * index)
	localparam logic [23:0] SRM_REG_BASE = 24'hfffb00;
	localparam logic [5:0] SRM_IDX_MCR = 6'h00;
	localparam logic [5:0] SRM_IDX_TST = 6'h02;
	localparam logic [5:0] SRM_IDX_BAR = 6'h04;

	// ram_module_config_register fields and reset value
	localparam int SRM_MCR_STOP_BIT = 15;
	localparam int SRM_MCR_RASP_BIT = 8;
	localparam logic [15:0] SRM_MCR_RST = 16'h0100;

	// array_base_register fields and reset value
	localparam int SRM_BAR_BASE_MSB = 15;
	localparam int SRM_BAR_BASE_LSB = 3;
	localparam int SRM_BAR_DIS_BIT = 0;
	localparam logic [15:0] SRM_BAR_RST = 16'h0001;

	// array geometry: 512 half-words in the upper 1024 bytes of 2 kbytes
	localparam int SRM_ARRAY_WORDS = 512;
	localparam int SRM_WA = 9;
	localparam int SRM_UPPER_BIT = 10;
	localparam int SRM_BLOCK_LSB = 11;

	// one bus cycle takes two system clocks
	localparam logic [1:0] SRM_BUS_CYCLE_CLKS = 2'h2;
	localparam logic [1:0] SRM_BUS_LAST = SRM_BUS_CYCLE_CLKS - 2'h1;

	// emulation read latency in clocks, matched to the microcode rom
	localparam int SRM_EMU_LAT = 1;

	typedef enum logic [1:0] {
		SRM_IDLE,
		SRM_XFER,
		SRM_ACK
	} srm_state_t;

endpackage : srm_pkg

/* srm_properties.sv */
// port checks for the standby ram controller
`timescale 1ns/1ns
module srm_properties (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [23:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic ack_o,
	// emulation
	input wire logic emu_sel_i
);
	wire reg_hit = adr_i[23:8] == 16'hfffb;
	wire one_half = sel_i[3:2] == 2'h0 || sel_i[1:0] == 2'h0;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_reg_ack_next: assert property ($rose(stb_i) && reg_hit |=> ack_o)
		else $error("register access not acked next cycle");
	a_half_no_early: assert property (
		$rose(stb_i) && !reg_hit && one_half |=> !ack_o [*2])
		else $error("single half acked early");
	a_half_two_clk: assert property (
		ack_o && !reg_hit && one_half |-> $past(stb_i, 3) && !$past(stb_i, 4))
		else $error("single half ack not at two clocks");
	a_long_two_cyc: assert property (
		ack_o && !reg_hit && !one_half |-> $past(stb_i, 5) && !$past(stb_i, 6))
		else $error("two half ack not at two bus cycles");
	a_ack_one_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_needs_req: assert property (ack_o |-> cyc_i && stb_i)
		else $error("ack without request");
	a_upper_only: assert property (ack_o && !reg_hit |-> adr_i[10])
		else $error("array acked in lower half of block");
	a_emu_no_ack: assert property (ack_o && !reg_hit |-> !emu_sel_i)
		else $error("array acked in emulation");
endmodule : srm_properties

/* srm_top.sv */
// standby ram mode control: wishbone slave, mode control and reset handling
// Functional notes
// R1 - array takes byte, word and long-word accesses in normal mode
// R2 - byte or aligned word access is one bus cycle of two clocks
// R3 - long-word or misaligned word access is two consecutive bus cycles
// R4 - synchronous reset during byte or word access lets it complete first
// R5 - reset in first word of long access completes only that word
// R6 - reset in second word of long access completes the whole access
// R7 - data integrity not guaranteed under asynchronous reset mid-access
// R8 - stop bit set puts module in stop, array disabled for external decode
// R9 - array keeps all stored data while stopped
// R10 - clearing stop bit returns array to normal access
// R11 - timer coprocessor, not module registers, selects emulation mode
// R12 - emulation timing matches the coprocessor microcode rom
// R13 - emulation mode ignores bus accesses to the array
// R14 - in emulation control register settings do not affect the array
// R15 - stop bit resets to zero, array starts in normal operation
// R16 - array disabled after reset; valid base write clears the disable flag
// R17 - array answers only in upper 1024 bytes of selected 2 kbyte block
// R18 - disabled, stopped or emulating array neither drives data nor acks
//
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
module srm_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [srm_pkg::SRM_ADR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [srm_pkg::SRM_DAT_W-1:0] dat_i,
	output logic [srm_pkg::SRM_DAT_W-1:0] dat_o,
	output logic ack_o,
	// bus cycle attributes
	input wire logic super_i,
	// timer coprocessor emulation port
	input wire logic emu_sel_i,
	input wire logic [srm_pkg::SRM_WA-1:0] emu_addr_i,
	output logic [15:0] emu_dat_o
);
	import srm_pkg::*;

	// lane merge for 16-bit registers on the low half of the bus
	function automatic logic [15:0] srm_merge16(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] be);
		logic [15:0] res;
		res = old_v;
		if (be[1]) begin
			res[15:8] = new_v[15:8];
		end
		if (be[0]) begin
			res[7:0] = new_v[7:0];
		end
		return res;
	endfunction : srm_merge16

	srm_mem_if mem_if ();

	srm_array u_array (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.mem(mem_if.array)
	);

	// state
	srm_state_t state_q;
	srm_state_t state_d;
	logic [1:0] cnt_q;
	logic half_q;
	logic two_q;
	logic second_q;
	logic reg_acc_q;
	logic rst_pend_q;
	logic [SRM_DAT_W-1:0] dat_q;

	// registers
	logic stop_q;
	logic rasp_q;
	logic [SRM_BAR_BASE_MSB-SRM_BAR_BASE_LSB:0] base_q;
	logic dis_q;

	// decode
	wire req = cyc_i & stb_i;
	wire reg_hit = adr_i[SRM_ADR_W-1:8] == SRM_REG_BASE[SRM_ADR_W-1:8];
	wire [5:0] reg_idx = adr_i[7:2];
	wire blk_hit = adr_i[SRM_ADR_W-1:SRM_BLOCK_LSB] == base_q;
	wire upper_hit = adr_i[SRM_UPPER_BIT]; // R17
	wire space_ok = ~rasp_q | super_i;
	wire arr_on = ~emu_sel_i & ~stop_q & ~dis_q; // R8 R10 R13 R14 R18
	wire arr_hit = ~reg_hit & arr_on & blk_hit & upper_hit & space_ok;
	wire hi_need = |sel_i[3:2];
	wire lo_need = |sel_i[1:0];
	wire two_need = hi_need & lo_need; // R3
	wire cyc_last = cnt_q == SRM_BUS_LAST; // R2
	wire in_first = two_q & ~second_q;

	// register read image
	wire [15:0] mcr_rd = {stop_q, 6'h00, rasp_q, 8'h00};
	wire [15:0] bar_rd = {base_q, 2'h0, dis_q};
	wire [15:0] reg_rd = (reg_idx == SRM_IDX_MCR) ? mcr_rd :
		(reg_idx == SRM_IDX_BAR) ? bar_rd : 16'h0000;

	// register writes at the acknowledging edge
	wire reg_wr = (state_q == SRM_ACK) & reg_acc_q & we_i;
	wire mcr_wr = reg_wr & (reg_idx == SRM_IDX_MCR);
	wire bar_wr = reg_wr & (reg_idx == SRM_IDX_BAR) & lo_need;
	wire [15:0] mcr_new = srm_merge16(mcr_rd, dat_i[15:0], sel_i[1:0]);
	wire [15:0] bar_new = srm_merge16(bar_rd, dat_i[15:0], sel_i[1:0]);
	wire base_valid = bar_new[SRM_BAR_BASE_MSB:SRM_BAR_BASE_LSB] !=
		SRM_REG_BASE[SRM_ADR_W-1:SRM_BLOCK_LSB];

	// reset waits for the current bus cycle to end
	wire rst_req = rst_i | rst_pend_q;
	wire quiet = (state_q == SRM_IDLE) | (state_q == SRM_ACK) |
		((state_q == SRM_XFER) & cyc_last & in_first); // R4 R5 R6
	wire do_rst = rst_req & quiet;

	// array port
	assign mem_if.addr = {adr_i[SRM_UPPER_BIT-1:2], ~half_q};
	assign mem_if.wdat = half_q ? dat_i[31:16] : dat_i[15:0];
	assign mem_if.be = half_q ? sel_i[3:2] : sel_i[1:0];
	assign mem_if.we = (state_q == SRM_XFER) & cyc_last & we_i; // R1
	assign mem_if.eaddr = emu_addr_i; // R11

	assign ack_o = state_q == SRM_ACK; // R18
	assign dat_o = dat_q;
	assign emu_dat_o = mem_if.erdat; // R12

	// next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			SRM_IDLE: begin
				if (req && reg_hit) begin
					state_d = SRM_ACK;
				end else if (req && arr_hit) begin
					state_d = SRM_XFER;
				end
			end
			SRM_XFER: begin
				if (cyc_last && !in_first) begin
					state_d = SRM_ACK;
				end
			end
			SRM_ACK: begin
				state_d = SRM_IDLE;
			end
			default: begin
				state_d = SRM_IDLE;
			end
		endcase
	end

	// sequencer
	always_ff @(posedge clk_i) begin
		if (do_rst) begin
			state_q <= SRM_IDLE;
			cnt_q <= 2'h0;
			half_q <= 1'b0;
			two_q <= 1'b0;
			second_q <= 1'b0;
			reg_acc_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == SRM_IDLE) begin
				cnt_q <= 2'h0;
				half_q <= hi_need;
				two_q <= two_need;
				second_q <= 1'b0;
				reg_acc_q <= req & reg_hit;
			end else if (state_q == SRM_XFER) begin
				cnt_q <= cyc_last ? 2'h0 : cnt_q + 2'h1;
				if (cyc_last && in_first) begin
					half_q <= 1'b0;
					second_q <= 1'b1;
				end
			end
		end
	end

	// reset held back while an access is in flight
	always_ff @(posedge clk_i) begin
		if (do_rst) begin
			rst_pend_q <= 1'b0;
		end else if (rst_i) begin
			rst_pend_q <= 1'b1; // R4
		end
	end

	// read data
	always_ff @(posedge clk_i) begin
		if (do_rst && state_q != SRM_ACK) begin
			dat_q <= 32'h0000_0000;
		end else if (state_q == SRM_IDLE && req && reg_hit) begin
			dat_q <= {16'h0000, reg_rd};
		end else if (state_q == SRM_IDLE && req && arr_hit) begin
			dat_q <= 32'h0000_0000;
		end else if (state_q == SRM_XFER && cyc_last && !we_i) begin
			if (half_q) begin
				dat_q[31:16] <= mem_if.rdat;
			end else begin
				dat_q[15:0] <= mem_if.rdat;
			end
		end
	end

	// configuration registers
	always_ff @(posedge clk_i) begin
		if (do_rst) begin
			stop_q <= SRM_MCR_RST[SRM_MCR_STOP_BIT]; // R15
			rasp_q <= SRM_MCR_RST[SRM_MCR_RASP_BIT];
			base_q <= SRM_BAR_RST[SRM_BAR_BASE_MSB:SRM_BAR_BASE_LSB];
			dis_q <= SRM_BAR_RST[SRM_BAR_DIS_BIT]; // R16
		end else begin
			if (mcr_wr) begin
				stop_q <= mcr_new[SRM_MCR_STOP_BIT]; // R8 R10
				rasp_q <= mcr_new[SRM_MCR_RASP_BIT];
			end
			if (bar_wr) begin
				base_q <= bar_new[SRM_BAR_BASE_MSB:SRM_BAR_BASE_LSB];
				if (base_valid) begin
					dis_q <= 1'b0; // R16
				end
			end
		end
	end

endmodule : srm_top

/* standby_ram_mode_control_tb.sv */
// self-checking bench for the standby ram controller
`timescale 1ns/1ns
module standby_ram_mode_control_tb;
	import srm_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack, ok, emu_sel = 1'b0;
	logic [23:0] a;
	logic [3:0] sel;
	logic [31:0] wd, rd, v, w2, ex;
	logic [8:0] emu_addr = 9'h0;
	logic [15:0] emu_dat;
	logic [31:0] exp_q[$];
	int error_cnt = 0, cmp_count = 0, cyc_cnt = 0;
	always #20 clk_i = ~clk_i;
	srm_top srm_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(a), .sel_i(sel), .dat_i(wd), .dat_o(rd),
		.ack_o(ack), .super_i(1'b1), .emu_sel_i(emu_sel),
		.emu_addr_i(emu_addr), .emu_dat_o(emu_dat));
	srm_cpu_model srm_cpu_model_i (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(a), .sel_o(sel), .dat_o(wd), .ack_i(ack));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done
	task automatic go(input logic w, input logic [23:0] ad,
		input logic [3:0] s, input logic [31:0] d, input logic e);
		srm_cpu_model_i.bus(w, ad, s, d, ok);
		chk({31'h0, ok}, {31'h0, e});
	endtask : go
	task automatic rdq(input logic [23:0] ad, input logic [31:0] e);
		exp_q.push_back(e);
		go(1'b0, ad, 4'hf, 32'h0, 1'b1);
	endtask : rdq
	always @(negedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0) begin
			chk(rd, exp_q.size() ? exp_q.pop_front() : 32'hx);
		end
	end
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 2000) begin
			error_cnt++;
			test_done();
		end
	end
	initial begin
		void'($urandom(32'h70af));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdq(24'hfffb00, 32'h100);
		rdq(24'hfffb10, 32'h1);
		go(1'b1, 24'h400, 4'hf, 32'h0, 1'b0);
		go(1'b1, 24'hfffb10, 4'hf, 32'h0, 1'b1);
		rdq(24'hfffb10, 32'h0);
		for (int i = 0; i < 4; i++) begin
			v = $urandom();
			w2 = $urandom();
			ex = {w2[31:8], v[7:0]};
			go(1'b1, 24'(32'h400 + i * 16), 4'hf, v, 1'b1);
			go(1'b1, 24'(32'h400 + i * 16), 4'hc, w2, 1'b1);
			go(1'b1, 24'(32'h400 + i * 16), 4'h6, w2, 1'b1);
			rdq(24'(32'h400 + i * 16), ex);
		end
		go(1'b1, 24'h200, 4'hf, v, 1'b0);
		go(1'b1, 24'hfffb00, 4'hf, 32'h8100, 1'b1);
		go(1'b1, 24'h430, 4'hf, v, 1'b0);
		go(1'b1, 24'hfffb00, 4'hf, 32'h100, 1'b1);
		rdq(24'h430, ex);
		emu_sel <= 1'b1;
		emu_addr <= 9'h18;
		go(1'b0, 24'h430, 4'hf, 32'h0, 1'b0);
		go(1'b1, 24'hfffb00, 4'hf, 32'h8100, 1'b1);
		@(negedge clk_i);
		chk({16'h0, emu_dat}, {16'h0, ex[31:16]});
		@(posedge clk_i);
		emu_addr <= 9'h19;
		@(posedge clk_i);
		@(negedge clk_i);
		chk({16'h0, emu_dat}, {16'h0, ex[15:0]});
		@(posedge clk_i);
		emu_sel <= 1'b0;
		go(1'b1, 24'hfffb00, 4'hf, 32'h100, 1'b1);
		for (int j = 0; j < 3; j++) begin
			go(1'b1, 24'h400, 4'hf, 32'h0, 1'b1);
			fork
				go(1'b1, 24'h400, j ? 4'hf : 4'hc, 32'h12345678, j != 1);
				begin
					repeat (j == 2 ? 3 : 1) @(posedge clk_i);
					rst_i <= 1'b1;
					@(posedge clk_i);
					rst_i <= 1'b0;
				end
			join
			go(1'b1, 24'hfffb10, 4'hf, 32'h0, 1'b1);
			rdq(24'h400, j == 2 ? 32'h12345678 : 32'h12340000);
		end
		test_done();
	end
endmodule : standby_ram_mode_control_tb
bind srm_top srm_properties srm_properties_i (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .adr_i(adr_i), .sel_i(sel_i),
	.ack_o(ack_o), .emu_sel_i(emu_sel_i));
